// ==== verilog/tpg_regs.svh ====
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH
`define IDX_ENABLE      8'h06
`define IDX_FORMAT      8'h09
`define IDX_SEL_A       8'h0a
`define IDX_SEL_B       8'h0b
`define IDX_CUST_HI     8'h0e
`define IDX_CUST_LO     8'h0f
`define IDX_STATUS      8'h10
`define BIT_ENABLE      1
`define BIT_FORMAT      0
`define BIT_ALIGN       1
`define RST_REG         8'h00
`define WORD_TOGGLE     14'h2aaa
`define WORD_DESKEW     14'h3aaa
`define LFSR_SEED       15'h0001
`endif

// ==== verilog/tpg_pkg.sv ====
package tpg_pkg;
  typedef enum logic [3:0] {
    SEL_NORMAL = 4'b0000,
    SEL_ZEROS  = 4'b0001,
    SEL_ONES   = 4'b0010,
    SEL_TOGGLE = 4'b0011,
    SEL_RAMP   = 4'b0100,
    SEL_CUSTOM = 4'b0101,
    SEL_DESKEW = 4'b0110,
    SEL_PRBS   = 4'b1000,
    SEL_SINE   = 4'b1001
  } pattern_sel_t;
  typedef struct packed {
    logic [13:0] b;
    logic [13:0] a;
  } sample_pair_t;
endpackage

// ==== verilog/dual_channel_test_pattern_gen.sv ====
// Contract
// R1: generated data replaces samples only while the enable bit is one
// R2: align bit zero lets channels run free; one restarts and steps together
// R3: format bit zero gives two's complement, one gives offset binary
// R4: channel A selector in bits 3-0, effective only while enabled
// R5: channel B selector in bits 7-4, same codes, only while enabled
// R6: 0000 passes samples, 0001 all zeros, 0010 all ones
// R7: 0011 alternates 2aaa and its complement on successive samples
// R8: 0100 ramps up by one per sample from 0 to 16383
// R9: ramp wraps to zero after its maximum and keeps counting
// R10: 0101 outputs the shared custom word every sample
// R11: custom word bits 13:6 in one register, 5:0 in next bits 7-2
// R12: 0110 outputs the constant deskew word 3aaa
// R13: 1000 outputs one new pseudo-random word per sample
// R14: prbs uses x^15+x^14+1 seeded nonzero at reset
// R15: 1001 repeats 0,2399,8192,13984,16383,13984,8192,2399
// R16: all registers reset to zero; reserved bits read back zero
`timescale 1ns/1ps
`include "tpg_regs.svh"

module sample_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sample_fifo

module dual_channel_test_pattern_gen #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic                  sample_valid,
  output logic                       sample_ready,
  input  wire tpg_pkg::sample_pair_t sample_in,
  output logic                       link_valid,
  input  wire logic                  link_ready,
  output tpg_pkg::sample_pair_t      link_data
);
  import tpg_pkg::*;

  logic        en_q;
  logic [7:0]  fmt_q;
  logic [7:0]  sel_q;
  logic [7:0]  cust_hi_q;
  logic [7:0]  cust_lo_q;
  logic        align_prev_q;
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic [31:0] rdata_q;
  logic        take;
  logic        restart;
  logic [13:0] custom;
  logic [13:0] raw [2];
  logic [13:0] word [2];
  logic [3:0]  chan_sel [2];
  logic [4:0]  fifo_level;
  sample_pair_t fifo_in;

  function automatic logic [31:0] reg_read(input logic [7:0] idx);
    unique case (idx)
      `IDX_ENABLE:  reg_read = {30'h0, en_q, 1'b0};
      `IDX_FORMAT:  reg_read = {24'h0, fmt_q};
      `IDX_SEL_A:   reg_read = {28'h0, sel_q[3:0]};
      `IDX_SEL_B:   reg_read = {24'h0, sel_q[7:4], 4'h0};
      `IDX_CUST_HI: reg_read = {24'h0, cust_hi_q};
      `IDX_CUST_LO: reg_read = {24'h0, cust_lo_q};
      `IDX_STATUS:  reg_read = {27'h0, fifo_level};
      default:      reg_read = 32'h0;
    endcase
  endfunction

  function automatic logic [13:0] sine_word(input logic [2:0] i);
    unique case (i)
      3'h0:         sine_word = 14'h0000;
      3'h1, 3'h7:   sine_word = 14'h095f;
      3'h2, 3'h6:   sine_word = 14'h2000;
      3'h3, 3'h5:   sine_word = 14'h36a0;
      3'h4:         sine_word = 14'h3fff;
    endcase
  endfunction

  // bus slave answers with zero wait states, so hreadyout never drops
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h0;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_idx_q  <= haddr[9:2];
      rdata_q   <= (hsel && htrans[1] && !hwrite) ?
                   reg_read(haddr[9:2]) : 32'h0;
    end
  end

  // only defined fields are stored, reserved bits stay zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_q      <= 1'b0; // [R16]
      fmt_q     <= `RST_REG; // [R16]
      sel_q     <= `RST_REG; // [R16]
      cust_hi_q <= `RST_REG; // [R16]
      cust_lo_q <= `RST_REG; // [R16]
    end else if (wr_pend_q) begin
      unique case (wr_idx_q)
        `IDX_ENABLE:  en_q <= hwdata[`BIT_ENABLE];
        `IDX_FORMAT:  fmt_q <= {6'h0, hwdata[1:0]};
        `IDX_SEL_A:   sel_q[3:0] <= hwdata[3:0]; // [R4]
        `IDX_SEL_B:   sel_q[7:4] <= hwdata[7:4]; // [R5]
        `IDX_CUST_HI: cust_hi_q <= hwdata[7:0]; // [R11]
        `IDX_CUST_LO: cust_lo_q <= {hwdata[7:2], 2'b00}; // [R11]
        default:      ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      align_prev_q <= 1'b0;
    end else begin
      align_prev_q <= fmt_q[`BIT_ALIGN];
    end
  end

  // a new selection while aligned also restarts, so channels stay in step
  assign restart = fmt_q[`BIT_ALIGN] && (!align_prev_q ||
                   (wr_pend_q && (wr_idx_q == `IDX_SEL_A ||
                                  wr_idx_q == `IDX_SEL_B))); // [R2]
  assign custom  = {cust_hi_q, cust_lo_q[7:2]}; // [R11]
  assign take    = sample_valid && sample_ready;
  assign chan_sel[0] = sel_q[3:0]; // [R4]
  assign chan_sel[1] = sel_q[7:4]; // [R5]
  assign raw[0] = sample_in.a;
  assign raw[1] = sample_in.b;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [13:0] ramp_q;
    logic        tog_q;
    logic [2:0]  sine_q;
    logic [14:0] lfsr_q;
    logic [13:0] coded;

    // generators advance only on accepted samples, so stalls hold them
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        ramp_q <= 14'h0;
        tog_q  <= 1'b0;
        sine_q <= 3'h0;
        lfsr_q <= `LFSR_SEED; // [R14]
      end else if (restart) begin
        ramp_q <= 14'h0; // [R2]
        tog_q  <= 1'b0;
        sine_q <= 3'h0;
        lfsr_q <= `LFSR_SEED;
      end else if (take) begin
        ramp_q <= ramp_q + 14'h1; // [R8] [R9]
        tog_q  <= !tog_q; // [R7]
        sine_q <= sine_q + 3'h1; // [R15]
        lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]}; // [R13] [R14]
      end
    end

    // coding is applied to converted samples only
    assign coded = fmt_q[`BIT_FORMAT] ?
                   {!raw[ch][13], raw[ch][12:0]} : raw[ch]; // [R3]

    always_comb begin
      word[ch] = coded;
      if (en_q) begin // [R1]
        unique case (chan_sel[ch])
          SEL_NORMAL: word[ch] = coded; // [R6]
          SEL_ZEROS:  word[ch] = 14'h0000; // [R6]
          SEL_ONES:   word[ch] = 14'h3fff; // [R6]
          SEL_TOGGLE: word[ch] = tog_q ? ~`WORD_TOGGLE : `WORD_TOGGLE; // [R7]
          SEL_RAMP:   word[ch] = ramp_q; // [R8]
          SEL_CUSTOM: word[ch] = custom; // [R10]
          SEL_DESKEW: word[ch] = `WORD_DESKEW; // [R12]
          SEL_PRBS:   word[ch] = lfsr_q[13:0]; // [R13]
          SEL_SINE:   word[ch] = sine_word(sine_q); // [R15]
          default:    word[ch] = 14'h0000;
        endcase
      end
    end
  end

  assign fifo_in.a = word[0];
  assign fifo_in.b = word[1];

  sample_fifo #(
    .WIDTH (28),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (fifo_in),
    .out_valid (link_valid),
    .out_ready (link_ready),
    .out_data  (link_data),
    .level     (fifo_level)
  );

  a_normal_pass: assert property (@(posedge clock) disable iff (!nrst) // [R1]
    take && !en_q && !fmt_q[0] |-> fifo_in.a == sample_in.a)
    else $error("sample not passed while disabled");
  a_offset_bin: assert property (@(posedge clock) disable iff (!nrst) // [R3]
    take && fmt_q[0] && (!en_q || sel_q[7:4] == 4'b0000) |->
    fifo_in.b == {!sample_in.b[13], sample_in.b[12:0]})
    else $error("offset binary msb wrong");
  a_fixed_words: assert property (@(posedge clock) disable iff (!nrst) // [R6]
    en_q && sel_q[3:0] == 4'b0010 |-> fifo_in.a == 14'h3fff)
    else $error("all ones word wrong");
  a_toggle_alt: assert property (@(posedge clock) disable iff (!nrst) // [R7]
    (take && en_q && sel_q[7:4] == 4'b0011 && !restart) ##1
    (en_q && sel_q[7:4] == 4'b0011) |-> fifo_in.b == ~$past(fifo_in.b))
    else $error("toggle did not alternate");
  a_ramp_step: assert property (@(posedge clock) disable iff (!nrst) // [R8]
    (take && en_q && sel_q[3:0] == 4'b0100 && !restart) ##1
    (en_q && sel_q[3:0] == 4'b0100) |->
    fifo_in.a == 14'($past(fifo_in.a) + 14'h1))
    else $error("ramp did not step by one");
  a_custom_word: assert property (@(posedge clock) disable iff (!nrst) // [R10]
    en_q && sel_q[3:0] == 4'b0101 |->
    fifo_in.a == {cust_hi_q, cust_lo_q[7:2]})
    else $error("custom word wrong");
  a_deskew_word: assert property (@(posedge clock) disable iff (!nrst) // [R12]
    en_q && sel_q[7:4] == 4'b0110 |-> fifo_in.b == 14'h3aaa)
    else $error("deskew word wrong");
  a_sine_next: assert property (@(posedge clock) disable iff (!nrst) // [R15]
    (take && en_q && sel_q[3:0] == 4'b1001 && fifo_in.a == 14'h0 &&
    !restart) ##1 (en_q && sel_q[3:0] == 4'b1001) |-> fifo_in.a == 14'h095f)
    else $error("sine sequence out of order");
  a_prbs_alive: assert property (@(posedge clock) disable iff (!nrst) // [R14]
    g_ch[0].lfsr_q != 15'h0 && g_ch[1].lfsr_q != 15'h0)
    else $error("prbs register stuck at zero");
  a_align_step: assert property (@(posedge clock) disable iff (!nrst) // [R2]
    $past(restart) |-> g_ch[0].ramp_q == 14'h0 &&
    g_ch[1].ramp_q == 14'h0 && g_ch[0].lfsr_q == g_ch[1].lfsr_q)
    else $error("aligned channels out of step");
endmodule // dual_channel_test_pattern_gen

// ==== testbench/link_sink.sv ====
`timescale 1ns/1ps
// downstream receiver; stall lets the bench back the stream up
module link_sink (
  input  wire logic                  stall,
  input  wire logic                  link_valid,
  output logic                       link_ready,
  input  wire tpg_pkg::sample_pair_t link_data,
  output logic                       got,
  output tpg_pkg::sample_pair_t      word
);
  import tpg_pkg::*;
  // ready does not wait on valid, as a real receiver need not
  assign link_ready = !stall;
  assign got        = link_valid && link_ready;
  assign word       = link_data;
endmodule // link_sink

// ==== testbench/dual_channel_test_pattern_gen_tb.sv ====
`timescale 1ns/1ps
`include "tpg_regs.svh"
module dual_channel_test_pattern_gen_tb;
  import tpg_pkg::*;
  typedef struct packed {
    logic [3:0]  sel;
    logic        en;
    logic        fmt;
    logic [13:0] e0;
    logic [13:0] e1;
  } row_t;
  localparam row_t ROWS [11] = '{
    '{4'h0, 1'b1, 1'b0, 14'h0123, 14'h0123},
    '{4'h0, 1'b1, 1'b1, 14'h2123, 14'h2123},
    '{4'h2, 1'b0, 1'b0, 14'h0123, 14'h0123},
    '{4'h1, 1'b1, 1'b0, 14'h0000, 14'h0000},
    '{4'h2, 1'b1, 1'b0, 14'h3fff, 14'h3fff},
    '{4'h3, 1'b1, 1'b0, 14'h2aaa, 14'h1555},
    '{4'h4, 1'b1, 1'b0, 14'h0000, 14'h0001},
    '{4'h5, 1'b1, 1'b0, 14'h1234, 14'h1234},
    '{4'h6, 1'b1, 1'b0, 14'h3aaa, 14'h3aaa},
    '{4'h8, 1'b1, 1'b0, 14'h0001, 14'h0002},
    '{4'h9, 1'b1, 1'b0, 14'h0000, 14'h095f}
  };
  localparam logic [13:0] SINE [8] = '{14'h0000, 14'h095f, 14'h2000,
    14'h36a0, 14'h3fff, 14'h36a0, 14'h2000, 14'h095f};
  localparam logic [7:0] RB_IDX [6] = '{8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f,
    8'h20};
  localparam logic [31:0] RB_EXP [6] = '{32'h03, 32'h0f, 32'hf0, 32'hff,
    32'hfc, 32'h00};
  // reserved bits are written as zero; the unmapped slot takes ones
  localparam logic [31:0] RB_WR [6] = '{32'h03, 32'h0f, 32'hf0, 32'hff,
    32'hfc, 32'hff};
  logic         clock        = 1'b0;
  logic         nrst         = 1'b0;
  logic         hsel         = 1'b0;
  logic         hwrite       = 1'b0;
  logic         sample_valid = 1'b0;
  logic         stall        = 1'b0;
  logic [31:0]  haddr        = 32'h0;
  logic [31:0]  hwdata       = 32'h0;
  logic [1:0]   htrans       = 2'h0;
  logic [2:0]   hsize        = 3'h2;
  sample_pair_t sample_in    = {14'h0123, 14'h0123};
  logic         hready;
  logic         hreadyout;
  logic         hresp;
  logic         sample_ready;
  logic         link_valid;
  logic         link_ready;
  logic         got;
  logic [31:0]  hrdata;
  logic [31:0]  rd;
  sample_pair_t link_data;
  sample_pair_t word;
  sample_pair_t q [$];
  int           errors       = 0;
  int           n_tests      = 0;
  int           k;

  always #4 clock = ~clock;
  assign hready = hreadyout;

  dual_channel_test_pattern_gen dual_channel_test_pattern_gen_inst (
    .clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .sample_valid, .sample_ready,
    .sample_in, .link_valid, .link_ready, .link_data);
  link_sink link_sink_inst (
    .stall, .link_valid, .link_ready, .link_data, .got, .word);

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge clock); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (!hreadyout);
    rd = hrdata;
  endtask

  // valid stays up between calls so back-to-back pushes never glitch it
  task automatic send(input logic [13:0] b, a, input logic last);
    sample_valid <= 1'b1;
    do @(posedge clock); while (!sample_ready);
    q.push_back({b, a});
    if (last)
      sample_valid <= 1'b0;
  endtask

  task automatic drain;
    for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge clock);
    check("drained", q.size(), 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock) begin
    if (nrst && got) begin
      check("queue", q.size() != 0, 32'h1);
      if (q.size() != 0)
        check("link_data", word, q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b1, `IDX_CUST_HI, 32'h48);
    bus(1'b1, `IDX_CUST_LO, 32'hd0);
    // align on: every selector write restarts both generators
    foreach (ROWS[i]) begin
      bus(1'b1, `IDX_ENABLE, {30'h0, ROWS[i].en, 1'b0});
      bus(1'b1, `IDX_FORMAT, {30'h0, 1'b1, ROWS[i].fmt});
      bus(1'b1, `IDX_SEL_A, {28'h0, ROWS[i].sel});
      bus(1'b1, `IDX_SEL_B, {24'h0, ROWS[i].sel, 4'h0});
      @(posedge clock);
      send(ROWS[i].e0, ROWS[i].e0, 1'b0);
      send(ROWS[i].e1, ROWS[i].e1, 1'b1);
      drain;
    end
    // stall the receiver until the buffer refuses
    bus(1'b1, `IDX_SEL_A, 32'h2);
    bus(1'b1, `IDX_SEL_B, 32'h20);
    stall <= 1'b1;
    sample_valid <= 1'b1;
    k = 0;
    repeat (24) begin
      @(posedge clock);
      if (sample_ready) begin
        k++;
        q.push_back({14'h3fff, 14'h3fff});
      end
    end
    sample_valid <= 1'b0;
    check("fill count", k, 32'd16);
    bus(1'b0, `IDX_STATUS, 32'h0);
    check("fill level", rd, 32'd16);
    stall <= 1'b0;
    drain;
    // ramp on A past its top code, sine on B, streamed back to back
    bus(1'b1, `IDX_SEL_A, 32'h4);
    bus(1'b1, `IDX_SEL_B, 32'h90);
    @(posedge clock);
    for (int j = 0; j < 16386; j++)
      send(SINE[j % 8], j[13:0], j == 16385);
    drain;
    foreach (RB_IDX[i]) begin
      bus(1'b1, RB_IDX[i], RB_WR[i]);
      @(posedge clock);
      bus(1'b0, RB_IDX[i], 32'h0);
      check("readback", rd, RB_EXP[i]);
    end
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    foreach (RB_IDX[i]) begin
      bus(1'b0, RB_IDX[i], 32'h0);
      check("reset value", rd, 32'h0);
    end
    bus(1'b0, `IDX_ENABLE, 32'h0);
    check("reset enable", rd, 32'h0);
    send(14'h0123, 14'h0123, 1'b1);
    drain;
    // align off: selector writes must not restart, the ramp keeps going
    bus(1'b1, `IDX_ENABLE, 32'h2);
    bus(1'b1, `IDX_SEL_A, 32'h4);
    send(14'h0123, 14'h0001, 1'b1);
    drain;
    bus(1'b1, `IDX_SEL_B, 32'h40);
    send(14'h0002, 14'h0002, 1'b1);
    drain;
    tally_and_finish;
  end
endmodule // dual_channel_test_pattern_gen_tb
